// file: core/can_timing_map.vh
`ifndef CAN_TIMING_MAP_VH
`define CAN_TIMING_MAP_VH
// Register byte offsets on the plain register port.
`define ADDR_W 16
`define OFF_GSR_LOW 16'h231A
`define OFF_GSR_HIGH 16'h231B
`define OFF_BCR_ONE_LOW 16'h231C
`define OFF_BCR_TWO_LOW 16'h231E
`define OFF_BCR_TWO_HIGH 16'h231F
`define OFF_GIF_LOW 16'h2320
`define OFF_MODE_CTRL 16'h2318
`define OFF_STAMP_PRE_LOW 16'h2330
`define OFF_STAMP_PRE_HIGH 16'h2331
`define OFF_STAMP_CNT_LOW 16'h2332
`define OFF_STAMP_CNT_HIGH 16'h2333
`define OFF_STAMP_HOLD_LOW 16'h2334
`define OFF_STAMP_HOLD_HIGH 16'h2335
// Field positions.
`define BIT_SAMPLE3 7
`define BIT_CFG_REQ 7
`define BIT_SLEEP_REQ 6
`define BIT_HALT_REQ 5
`define BIT_STAMP_CLR 1
`define BIT_SW_RESET 0
`define BIT_STAMP_OVF 3
// Reset values.
`define RST_MODE_CTRL 8'h80
`define RST_TX_SLOT 4'hF
// Processing count in core clock cycles, error counter levels and triple-sampling prescaler floor.
`define PROC_CYCLES 3'h4
`define PASSIVE_LEVEL 9'h080
`define WARN_LEVEL 9'h060
`define MIN_PRESC_TRIPLE 8'h04
`endif

// file: core/can_bit_timing.v
// Function
// R01 - Quantum equals prescaler plus one core clocks
// R02 - Core clock is system clock halved
// R03 - Bit is sync, phase one, phase two
// R04 - Sync segment is always one quantum
// R05 - Software keeps bit at least ten clocks
// R06 - Software keeps phase one not below two
// R07 - Four core clocks processing after sample
// R08 - Jump width field gives one to four
// R09 - Resynchronise on receive falling edges outside the sync segment
// R10 - Software keeps jump not above phase two
// R11 - Triple sampling takes majority of three
// R12 - Prescaler below four forces single sampling
// R13 - Software keeps phase two long enough
// R14 - Free-running sixteen bit stamp counter
// R15 - Stamp advances per bit, halts config/sleep
// R16 - Stamp counter readable and writable always
// R17 - Stamp ticks every bit times prescale+1
// R18 - Overflow sets status and flag, one clears
// R19 - Hold register captures stamp on success
// R20 - Success points differ for rx and tx
// R21 - Stamp and hold cleared on config/sleep entries
// R22 - Transmit slot field reports mailbox or none
// R23 - Passive at 128, warning above 96
// R24 - Sample point between the phase segments
module can_bit_timing (
    input wire clk_sys,
    input wire rst_n,
    input wire [15:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire can_rx,
    input wire rx_ok_pulse,
    input wire tx_ok_pulse,
    input wire [3:0] tx_slot_mailbox,
    input wire slot_valid,
    input wire receiving_flag,
    input wire transmitting_flag,
    input wire bus_off_flag,
    input wire [8:0] tx_err_count,
    input wire [7:0] rx_err_count,
    output reg sample_point,
    output reg sampled_bit,
    output reg bit_valid,
    output reg [15:0] mailbox_stamp_value
);
`include "can_timing_map.vh"

    reg rst_a_q;
    reg rst_b_q;
    wire rst_l;
    reg rx_a_q;
    reg rx_b_q;
    reg rx_prev_q;
    reg half_q;
    reg [7:0] presc_q;
    reg [7:0] q_cnt_q;
    reg [1:0] seg_q;
    reg [4:0] tq_q;
    reg [7:0] bcr_one_q;
    reg [7:0] bcr_two_q;
    reg [1:0] resync_jump_width;
    reg [7:0] mode_q;
    reg config_mode_ack;
    reg sleep_ack;
    reg halt_ack;
    reg [3:0] stamp_prescale;
    reg [3:0] stamp_pre_cnt_q;
    reg [15:0] stamp_counter;
    reg stamp_overflow_status;
    reg stamp_overflow_irq_flag;
    reg [2:0] smp_hist_q;
    reg [2:0] proc_cnt_q;
    reg bit_end_q;
    reg [3:0] slot_q;
    reg err_passive_flag;
    reg err_warning_flag;
    reg bus_off_q;
    reg rm_q;
    reg tm_q;
    wire [3:0] phase_segment_one;
    wire [2:0] phase_segment_two;
    wire triple_sample_select;
    wire triple_on;
    wire tq_tick;
    wire fall_edge;
    wire [4:0] seg_len;
    wire [4:0] sjw_len;
    wire sw_reset;
    wire cfg_enter;
    wire sleep_enter;
    wire stamp_clear;
    wire stamp_pre_wr;
    wire rd_hit;

    localparam [1:0] SEG_SYNC = 2'd0;
    localparam [1:0] SEG_ONE = 2'd1;
    localparam [1:0] SEG_TWO = 2'd2;

    // Reset is released through two flip-flops.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_a_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_b_q <= rst_a_q;
        end
    end
    assign rst_l = rst_b_q;

    assign phase_segment_one = bcr_two_q[3:0];
    assign phase_segment_two = bcr_two_q[6:4];
    assign triple_sample_select = bcr_two_q[`BIT_SAMPLE3];
    // Majority voting needs room in the quantum, so small prescalers skip it.
    assign triple_on = triple_sample_select &&
        (bcr_one_q >= `MIN_PRESC_TRIPLE); // [R12]
    assign sjw_len = {3'b000, resync_jump_width} + 5'd1; // [R08]
    assign seg_len = (seg_q == SEG_SYNC) ? 5'd1 : // [R04]
        (seg_q == SEG_ONE) ? {1'b0, phase_segment_one} + 5'd1 :
        {2'b00, phase_segment_two} + 5'd1; // [R03]
    assign tq_tick = half_q && (presc_q == bcr_one_q); // [R01]
    assign fall_edge = rx_prev_q && !rx_b_q;
    assign sw_reset = reg_wr && (reg_addr == `OFF_MODE_CTRL) &&
        reg_wdata[`BIT_SW_RESET];
    assign cfg_enter = mode_q[`BIT_CFG_REQ] && !config_mode_ack;
    assign sleep_enter = mode_q[`BIT_SLEEP_REQ] && !sleep_ack;
    assign stamp_pre_wr = reg_wr && (reg_addr == `OFF_STAMP_PRE_LOW);
    assign stamp_clear = sw_reset || cfg_enter || sleep_enter ||
        stamp_pre_wr ||
        (reg_wr && (reg_addr == `OFF_MODE_CTRL) &&
        reg_wdata[`BIT_STAMP_CLR]); // [R21]

    // Receive pin passes two flip-flops; edge logic reads the second and its one-cycle delayed copy.
    always @(posedge clk_sys or negedge rst_l) begin
        if (!rst_l) begin
            rx_a_q <= 1'b1;
            rx_b_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            rx_a_q <= can_rx;
            rx_b_q <= rx_a_q;
            rx_prev_q <= rx_b_q;
        end
    end

    // Core clock enable at half the system rate, quantum prescaler on it.
    always @(posedge clk_sys or negedge rst_l) begin
        if (!rst_l) begin
            half_q <= 1'b0;
            presc_q <= 8'h00;
        end else begin
            half_q <= ~half_q; // [R02]
            if (half_q) begin
                if (presc_q == bcr_one_q)
                    presc_q <= 8'h00;
                else
                    presc_q <= presc_q + 8'h01; // [R01]
            end
        end
    end

    // Segment sequencer with resynchronisation on falling edges.
    always @(posedge clk_sys or negedge rst_l) begin
        if (!rst_l) begin
            seg_q <= SEG_SYNC;
            tq_q <= 5'd0;
            sample_point <= 1'b0;
            bit_end_q <= 1'b0;
        end else begin
            sample_point <= 1'b0;
            bit_end_q <= 1'b0;
            if (config_mode_ack || sleep_ack) begin
                seg_q <= SEG_SYNC;
                tq_q <= 5'd0;
            end else if (fall_edge && seg_q != SEG_SYNC) begin // [R09]
                if (seg_q == SEG_ONE) begin
                    // Late edge: lengthen phase one by at most the jump.
                    if (tq_q > sjw_len)
                        tq_q <= tq_q - sjw_len; // [R08]
                    else
                        tq_q <= 5'd0;
                end else if ((seg_len - tq_q) <= sjw_len) begin
                    // Early edge within the jump: end the bit, restart.
                    seg_q <= SEG_ONE;
                    tq_q <= 5'd0;
                    bit_end_q <= 1'b1; // [R08]
                end else begin
                    // Early edge beyond the jump: shorten by the jump only.
                    tq_q <= tq_q + sjw_len; // [R08]
                end
            end else if (tq_tick) begin
                case (seg_q)
                    SEG_SYNC: begin
                        seg_q <= SEG_ONE;
                        tq_q <= 5'd0;
                    end
                    SEG_ONE: begin
                        if (tq_q + 5'd1 >= seg_len) begin
                            seg_q <= SEG_TWO;
                            tq_q <= 5'd0;
                            sample_point <= 1'b1; // [R24]
                        end else
                            tq_q <= tq_q + 5'd1;
                    end
                    SEG_TWO: begin
                        if (tq_q + 5'd1 >= seg_len) begin
                            seg_q <= SEG_SYNC;
                            tq_q <= 5'd0;
                            bit_end_q <= 1'b1;
                        end else
                            tq_q <= tq_q + 5'd1;
                    end
                    default: begin
                        seg_q <= SEG_SYNC;
                        tq_q <= 5'd0;
                    end
                endcase
            end
        end
    end

    // Sample history and processing interval before the level is valid.
    always @(posedge clk_sys or negedge rst_l) begin
        if (!rst_l) begin
            smp_hist_q <= 3'b111;
            proc_cnt_q <= 3'd0;
            sampled_bit <= 1'b1;
            bit_valid <= 1'b0;
        end else begin
            bit_valid <= 1'b0;
            if (half_q && seg_q == SEG_ONE)
                smp_hist_q <= {smp_hist_q[1:0], rx_b_q};
            if (sample_point) begin
                proc_cnt_q <= `PROC_CYCLES; // [R07]
                if (triple_on)
                    sampled_bit <= (smp_hist_q[0] & smp_hist_q[1]) |
                        (smp_hist_q[0] & smp_hist_q[2]) |
                        (smp_hist_q[1] & smp_hist_q[2]); // [R11]
                else
                    sampled_bit <= rx_b_q;
            end else if (proc_cnt_q != 3'd0 && half_q) begin
                proc_cnt_q <= proc_cnt_q - 3'd1;
                if (proc_cnt_q == 3'd1)
                    bit_valid <= 1'b1; // [R07]
            end
        end
    end

    // Mode acknowledges follow the requests one cycle later.
    always @(posedge clk_sys or negedge rst_l) begin
        if (!rst_l) begin
            config_mode_ack <= 1'b1;
            sleep_ack <= 1'b0;
            halt_ack <= 1'b0;
        end else begin
            config_mode_ack <= mode_q[`BIT_CFG_REQ];
            sleep_ack <= mode_q[`BIT_SLEEP_REQ];
            halt_ack <= mode_q[`BIT_HALT_REQ];
        end
    end

    // Stamp counter, prescaler and hold register.
    always @(posedge clk_sys or negedge rst_l) begin
        if (!rst_l) begin
            stamp_counter <= 16'h0000;
            stamp_pre_cnt_q <= 4'h0;
            mailbox_stamp_value <= 16'h0000;
        end else if (stamp_clear) begin
            stamp_counter <= 16'h0000; // [R21]
            stamp_pre_cnt_q <= 4'h0;
            mailbox_stamp_value <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == `OFF_STAMP_CNT_LOW)
                stamp_counter[7:0] <= reg_wdata; // [R16]
            else if (reg_wr && reg_addr == `OFF_STAMP_CNT_HIGH)
                stamp_counter[15:8] <= reg_wdata; // [R16]
            else if (bit_end_q && !config_mode_ack && !sleep_ack) begin
                if (stamp_pre_cnt_q >= stamp_prescale) begin // [R17]
                    stamp_pre_cnt_q <= 4'h0;
                    stamp_counter <= stamp_counter + 16'h0001; // [R14]
                end else
                    stamp_pre_cnt_q <= stamp_pre_cnt_q + 4'h1; // [R15]
            end
            if (rx_ok_pulse || tx_ok_pulse) // [R20]
                mailbox_stamp_value <= stamp_counter; // [R19]
        end
    end

    // Overflow flags; a new overflow wins over a flag clear write in the same cycle, a software reset wins over it.
    always @(posedge clk_sys or negedge rst_l) begin
        if (!rst_l) begin
            stamp_overflow_status <= 1'b0;
            stamp_overflow_irq_flag <= 1'b0;
        end else if (bit_end_q && !config_mode_ack && !sleep_ack &&
            !stamp_clear && stamp_pre_cnt_q >= stamp_prescale &&
            stamp_counter == 16'hFFFF) begin
            stamp_overflow_status <= 1'b1; // [R18]
            stamp_overflow_irq_flag <= 1'b1;
        end else if (sw_reset || (reg_wr && reg_addr == `OFF_GIF_LOW &&
            reg_wdata[`BIT_STAMP_OVF])) begin
            stamp_overflow_status <= 1'b0; // [R18]
            stamp_overflow_irq_flag <= 1'b0;
        end
    end

    // Software registers.
    always @(posedge clk_sys or negedge rst_l) begin
        if (!rst_l) begin
            bcr_one_q <= 8'h00;
            bcr_two_q <= 8'h00;
            resync_jump_width <= 2'b00;
            mode_q <= `RST_MODE_CTRL;
            stamp_prescale <= 4'h0;
        end else if (sw_reset) begin
            mode_q <= `RST_MODE_CTRL;
            stamp_prescale <= 4'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `OFF_BCR_ONE_LOW: bcr_one_q <= reg_wdata;
                `OFF_BCR_TWO_LOW: bcr_two_q <= reg_wdata;
                `OFF_BCR_TWO_HIGH: resync_jump_width <= reg_wdata[1:0];
                `OFF_MODE_CTRL: mode_q <= {reg_wdata[7:2], 2'b00};
                `OFF_STAMP_PRE_LOW: stamp_prescale <= reg_wdata[3:0];
                default: mode_q <= mode_q;
            endcase
        end
    end

    // Status snapshot of the surrounding controller.
    always @(posedge clk_sys or negedge rst_l) begin
        if (!rst_l) begin
            slot_q <= `RST_TX_SLOT;
            err_passive_flag <= 1'b0;
            err_warning_flag <= 1'b0;
            bus_off_q <= 1'b0;
            rm_q <= 1'b0;
            tm_q <= 1'b0;
        end else begin
            slot_q <= slot_valid ? tx_slot_mailbox : `RST_TX_SLOT; // [R22]
            err_passive_flag <= (tx_err_count >= `PASSIVE_LEVEL) ||
                ({1'b0, rx_err_count} >= `PASSIVE_LEVEL); // [R23]
            err_warning_flag <= (tx_err_count > `WARN_LEVEL) ||
                ({1'b0, rx_err_count} > `WARN_LEVEL); // [R23]
            bus_off_q <= bus_off_flag;
            rm_q <= receiving_flag;
            tm_q <= transmitting_flag;
        end
    end

    // Read data stand one cycle after the read strobe; unmapped reads zero.
    assign rd_hit = reg_rd;
    always @(posedge clk_sys or negedge rst_l) begin
        if (!rst_l)
            reg_rdata <= 8'h00;
        else if (rd_hit) begin
            case (reg_addr)
                `OFF_GSR_LOW: reg_rdata <= {config_mode_ack, sleep_ack,
                    halt_ack, 1'b0, stamp_overflow_status, bus_off_q,
                    err_passive_flag, err_warning_flag};
                `OFF_GSR_HIGH: reg_rdata <= {slot_q, rm_q, tm_q, 2'b00};
                `OFF_BCR_ONE_LOW: reg_rdata <= bcr_one_q;
                `OFF_BCR_TWO_LOW: reg_rdata <= bcr_two_q;
                `OFF_BCR_TWO_HIGH: reg_rdata <= {6'h00, resync_jump_width};
                `OFF_GIF_LOW: reg_rdata <= {4'h0, stamp_overflow_irq_flag,
                    3'b000};
                `OFF_MODE_CTRL: reg_rdata <= mode_q;
                `OFF_STAMP_PRE_LOW: reg_rdata <= {4'h0, stamp_prescale};
                `OFF_STAMP_CNT_LOW: reg_rdata <= stamp_counter[7:0];
                `OFF_STAMP_CNT_HIGH: reg_rdata <= stamp_counter[15:8];
                `OFF_STAMP_HOLD_LOW: reg_rdata <= mailbox_stamp_value[7:0];
                `OFF_STAMP_HOLD_HIGH: reg_rdata <= mailbox_stamp_value[15:8];
                default: reg_rdata <= 8'h00;
            endcase
        end else
            reg_rdata <= 8'h00;
    end
endmodule // can_bit_timing

// file: dv/can_bit_timing_asserts.sv
`include "can_timing_map.vh"
module can_bit_timing_asserts (
    input wire clk_sys,
    input wire rst_n,
    input wire [15:0] reg_addr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire rx_ok_pulse,
    input wire tx_ok_pulse,
    input wire slot_valid,
    input wire [8:0] tx_err_count,
    input wire [7:0] rx_err_count,
    input wire sample_point,
    input wire sampled_bit,
    input wire bit_valid,
    input wire [15:0] mailbox_stamp_value
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // The evaluation slot trails each sample by exactly four core clocks.
    a_proc_after_sample: assert property (sample_point |-> ##8 bit_valid)
        else $error("bit_valid missing after sample point");
    a_proc_has_cause: assert property (bit_valid |-> $past(sample_point, 8))
        else $error("bit_valid without sample point");
    // Even the shortest legal bit leaves a gap after each sample.
    a_sample_is_pulse: assert property (sample_point |=> !sample_point [*4])
        else $error("sample points too close");
    a_level_after_sample: assert property ($changed(sampled_bit) |-> $past(sample_point))
        else $error("bus level moved off the sample point");
    // The hold value moves only on frame success or on a clear.
    a_hold_cause: assert property ($changed(mailbox_stamp_value) |->
        $past(rx_ok_pulse || tx_ok_pulse) || mailbox_stamp_value == 16'h0000)
        else $error("hold register changed without cause");
    // Status levels are registered, so the inputs must be steady first.
    a_slot_none: assert property (reg_rd && reg_addr == `OFF_GSR_HIGH &&
        !slot_valid && $past(!slot_valid) |=> reg_rdata[7:4] == 4'hF)
        else $error("empty slot not shown as all ones");
    a_passive_level: assert property (reg_rd && reg_addr == `OFF_GSR_LOW &&
        tx_err_count >= `PASSIVE_LEVEL && $past(tx_err_count) >= `PASSIVE_LEVEL
        |=> reg_rdata[1])
        else $error("passive bit missing");
    a_warn_quiet: assert property (reg_rd && reg_addr == `OFF_GSR_LOW &&
        tx_err_count <= `WARN_LEVEL && rx_err_count <= `WARN_LEVEL &&
        $past(tx_err_count) <= `WARN_LEVEL && $past(rx_err_count) <= `WARN_LEVEL
        |=> !reg_rdata[0])
        else $error("warning bit set at or below level");

    c_sample: cover property (sample_point);
    c_dominant: cover property (bit_valid && !sampled_bit);
    c_rx_ok: cover property (rx_ok_pulse);
    c_tx_ok: cover property (tx_ok_pulse);
endmodule // can_bit_timing_asserts

bind can_bit_timing can_bit_timing_asserts chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_ok_pulse(rx_ok_pulse),
    .tx_ok_pulse(tx_ok_pulse), .slot_valid(slot_valid),
    .tx_err_count(tx_err_count), .rx_err_count(rx_err_count),
    .sample_point(sample_point), .sampled_bit(sampled_bit),
    .bit_valid(bit_valid), .mailbox_stamp_value(mailbox_stamp_value)
);

// file: dv/can_node_model.sv
module can_node_model #(
    parameter int BIT_CLKS = 24
) (
    input wire clk_sys,
    output logic can_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    // The bus rests recessive between frames, as termination pulls it.
    initial can_rx = 1'b1;

    // Bits leave most significant first, each one bit time long.
    task send_bits(input [8:0] bits);
        int i;
        for (i = 8; i >= 0; i--) begin
            @(posedge clk_sys);
            can_rx <= bits[i];
            repeat (BIT_CLKS - 1) @(posedge clk_sys);
        end
        @(posedge clk_sys);
        can_rx <= 1'b1;
    endtask
endmodule // can_node_model

// file: dv/can_bit_timing_tb.sv
`include "can_timing_map.vh"
module can_bit_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rx_ok_pulse = 1'b0;
    logic tx_ok_pulse = 1'b0, slot_valid = 1'b0, bus_off_flag = 1'b0;
    logic receiving_flag = 1'b0, transmitting_flag = 1'b0;
    logic [3:0] tx_slot_mailbox = 4'h0;
    logic [8:0] tx_err_count = 9'h000;
    logic [7:0] rx_err_count = 8'h00;
    logic [7:0] reg_rdata, v0, v1;
    logic sample_point, sampled_bit, bit_valid;
    logic [15:0] mailbox_stamp_value;
    wire can_rx;
    int bad_count = 0;
    int checked = 0;

    // The bit time of the node model equals the programmed one: 24 clocks.
    can_bit_timing dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .can_rx(can_rx),
        .rx_ok_pulse(rx_ok_pulse), .tx_ok_pulse(tx_ok_pulse),
        .tx_slot_mailbox(tx_slot_mailbox), .slot_valid(slot_valid),
        .receiving_flag(receiving_flag),
        .transmitting_flag(transmitting_flag), .bus_off_flag(bus_off_flag),
        .tx_err_count(tx_err_count), .rx_err_count(rx_err_count),
        .sample_point(sample_point), .sampled_bit(sampled_bit),
        .bit_valid(bit_valid), .mailbox_stamp_value(mailbox_stamp_value));
    can_node_model #(.BIT_CLKS(24)) node (.clk_sys(clk_sys), .can_rx(can_rx));

    always #10 clk_sys = ~clk_sys;

    // Bus tasks drop the strobe then step off the edge, so no signal is
    // assigned twice in one time step when calls follow each other.
    task wr(input [15:0] a, input [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input [15:0] a, output [7:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task rc(input [15:0] a, input [7:0] e);
        rd(a, v0);
        `CHK(v0, e)
    endtask
    task wait_sp;
        int i;
        // Always step past the current pulse so each call finds a new one.
        for (i = 0; i < 60; i++) begin
            @(posedge clk_sys);
            #1;
            if (sample_point === 1'b1)
                break;
        end
        `CHK(sample_point, 1'b1)
    endtask
    task pulse_ok(input rx, input [15:0] e);
        rx_ok_pulse <= rx;
        tx_ok_pulse <= !rx;
        @(posedge clk_sys);
        rx_ok_pulse <= 1'b0;
        tx_ok_pulse <= 1'b0;
        #1;
        `CHK(mailbox_stamp_value, e)
    endtask
    task st(input [8:0] t, input [7:0] r, input [7:0] e);
        tx_err_count <= t;
        rx_err_count <= r;
        repeat (3) @(posedge clk_sys);
        rc(`OFF_GSR_LOW, e);
    endtask

    task t_reset;
        rc(`OFF_GSR_LOW, 8'h80);
        rc(`OFF_GSR_HIGH, 8'hF0);
        rc(`OFF_STAMP_CNT_LOW, 8'h00);
        rc(`OFF_STAMP_PRE_LOW, 8'h00);
        rc(`OFF_STAMP_PRE_HIGH, 8'h00);
        rc(16'h2300, 8'h00);
        $display("t_reset done");
    endtask
    task t_counter;
        wr(`OFF_STAMP_CNT_LOW, 8'h5A);
        wr(`OFF_STAMP_CNT_HIGH, 8'hC3);
        repeat (60) @(posedge clk_sys);
        rc(`OFF_STAMP_CNT_LOW, 8'h5A);
        rc(`OFF_STAMP_CNT_HIGH, 8'hC3);
        wr(`OFF_STAMP_PRE_LOW, 8'h00);
        rc(`OFF_STAMP_CNT_HIGH, 8'h00);
        $display("t_counter done");
    endtask
    // Quantum of two core clocks, 3 + 2 phase quanta: 24 clocks a bit.
    task t_config;
        wr(`OFF_BCR_ONE_LOW, 8'h01);
        wr(`OFF_BCR_TWO_LOW, 8'h12);
        wr(`OFF_BCR_TWO_HIGH, 8'h01);
        wr(`OFF_MODE_CTRL, 8'h00);
        repeat (8) @(posedge clk_sys);
        rc(`OFF_GSR_LOW, 8'h00);
        $display("t_config done");
    endtask
    task t_rx;
        int i;
        wait_sp;
        fork
            node.send_bits(9'h0A5);
        join_none
        wait_sp;
        for (i = 7; i >= 0; i--) begin
            wait_sp;
            @(posedge clk_sys);
            #1;
            `CHK(sampled_bit, v0[i] | 1'b0)
        end
        $display("t_rx done");
    endtask
    // Reads 240 and 480 clocks apart must see exactly ten ticks.
    task t_rate;
        wr(`OFF_STAMP_PRE_LOW, 8'h00);
        rd(`OFF_STAMP_CNT_LOW, v0);
        repeat (239) @(posedge clk_sys);
        rd(`OFF_STAMP_CNT_LOW, v1);
        `CHK(v1, v0 + 8'h0A)
        wr(`OFF_STAMP_PRE_LOW, 8'h01);
        rd(`OFF_STAMP_CNT_LOW, v0);
        repeat (479) @(posedge clk_sys);
        rd(`OFF_STAMP_CNT_LOW, v1);
        `CHK(v1, v0 + 8'h0A)
        $display("t_rate done");
    endtask
    task t_ovf;
        wr(`OFF_STAMP_PRE_LOW, 8'h00);
        wr(`OFF_STAMP_CNT_HIGH, 8'hFF);
        wr(`OFF_STAMP_CNT_LOW, 8'hFF);
        repeat (60) @(posedge clk_sys);
        rc(`OFF_GSR_LOW, 8'h08);
        rc(`OFF_GIF_LOW, 8'h08);
        wr(`OFF_GIF_LOW, 8'h08);
        rc(`OFF_GSR_LOW, 8'h00);
        rc(`OFF_GIF_LOW, 8'h00);
        $display("t_ovf done");
    endtask
    task t_status;
        st(9'h060, 8'h60, 8'h00);
        st(9'h061, 8'h00, 8'h01);
        st(9'h000, 8'h61, 8'h01);
        st(9'h07F, 8'h00, 8'h01);
        st(9'h080, 8'h00, 8'h03);
        st(9'h000, 8'h80, 8'h03);
        slot_valid <= 1'b1;
        tx_slot_mailbox <= 4'hE;
        receiving_flag <= 1'b1;
        st(9'h000, 8'h00, 8'h00);
        rc(`OFF_GSR_HIGH, 8'hE8);
        slot_valid <= 1'b0;
        receiving_flag <= 1'b0;
        transmitting_flag <= 1'b1;
        bus_off_flag <= 1'b1;
        st(9'h000, 8'h00, 8'h04);
        rc(`OFF_GSR_HIGH, 8'hF4);
        bus_off_flag <= 1'b0;
        $display("t_status done");
    endtask
    // A slow prescale keeps the counter still while the hold is tried.
    task t_hold;
        wr(`OFF_STAMP_PRE_LOW, 8'h0F);
        wr(`OFF_STAMP_CNT_HIGH, 8'h12);
        wr(`OFF_STAMP_CNT_LOW, 8'h34);
        pulse_ok(1'b1, 16'h1234);
        rc(`OFF_STAMP_HOLD_LOW, 8'h34);
        wr(`OFF_STAMP_CNT_LOW, 8'h78);
        pulse_ok(1'b0, 16'h1278);
        wr(`OFF_MODE_CTRL, 8'h80);
        repeat (4) @(posedge clk_sys);
        rc(`OFF_STAMP_CNT_HIGH, 8'h00);
        `CHK(mailbox_stamp_value, 16'h0000)
        $display("t_hold done");
    endtask

    task finish_test;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence; the node sends a lead dominant bit, then 8'hA5.
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset;
        t_counter;
        t_config;
        v0 = 8'hA5;
        t_rx;
        // Triple select with a small prescaler must still sample once.
        wr(`OFF_BCR_TWO_LOW, 8'h92);
        v0 = 8'hA5;
        t_rx;
        t_rate;
        t_ovf;
        t_status;
        t_hold;
        finish_test;
    end

    // The sequence needs about 1500 clocks; this cuts off a hang.
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        finish_test;
    end
endmodule // can_bit_timing_tb
